// >>> design/pcs_pkg.sv
package pcs_pkg;

  // Configuration dword index holding the command and status halves
  localparam logic [5:0] CFG_CMD_STAT_IDX = 6'h01;
  // Byte offsets of the two register halves
  localparam logic [7:0] PCI_COMMAND_OFS = 8'h04;
  localparam logic [7:0] PCI_STATUS_OFS = 8'h06;

  // Command register bit positions
  localparam int CMD_IO_EN_BIT = 0;
  localparam int CMD_MEM_EN_BIT = 1;
  localparam int CMD_INIT_EN_BIT = 2;
  localparam int CMD_PAR_RESP_BIT = 6;
  localparam int CMD_SERR_EN_BIT = 8;

  // Status register bit positions
  localparam int STS_CAP_LIST_BIT = 4;
  localparam int STS_FAST_BUS_BIT = 5;
  localparam int STS_DPAR_BIT = 8;
  localparam int STS_DEVSEL_LO_BIT = 9;
  localparam int STS_SIG_TABT_BIT = 11;
  localparam int STS_RCV_TABT_BIT = 12;
  localparam int STS_RCV_MABT_BIT = 13;
  localparam int STS_SIG_SERR_BIT = 14;
  localparam int STS_DET_PERR_BIT = 15;

  // Fixed DEVSEL timing field: slow decode
  localparam logic [1:0] STS_DEVSEL_SLOW = 2'h2;

  // Values after reset
  localparam logic [15:0] CMD_RESET_VAL = 16'h0000;
  localparam logic [4:0] FLAG_RESET_VAL = 5'h00;

  // Writable masks of command
  localparam logic [15:0] CMD_RW_TARGET_MASK = 16'h0143;
  localparam logic [15:0] CMD_RW_INIT_MASK = 16'h0004;

  // Config access state machine
  typedef enum logic [1:0]
  {
    CFG_IDLE = 2'b00,
    CFG_DATA = 2'b01,
    CFG_DONE = 2'b11
  } pcs_cfg_state_type;

endpackage : pcs_pkg

// >>> design/pcs_sync.sv
`timescale 1ns/1ps
// Two-flop synchroniser for pin-side levels
module pcs_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Data
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_ff;

  // First stage is read only by the second
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      meta_ff <= '0;
      dout <= '0;
    end
    else
    begin
      meta_ff <= din;
      dout <= meta_ff;
    end
  end

endmodule : pcs_sync

// >>> design/pcs_flag.sv
`timescale 1ns/1ps
// Sticky flag: hardware sets, write-one clears, set beats clear
module pcs_flag #(
  parameter bit PRESENT = 1'b1
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Set and clear strobes
  input wire logic set_evt,
  input wire logic clr_evt,
  output logic flag_ff
);

  logic nxt_flag;

  // A missing build option keeps the flag at zero
  always_comb
  begin
    if (!PRESENT)
      nxt_flag = 1'b0;
    else if (set_evt)
      nxt_flag = 1'b1;
    else if (clr_evt)
      nxt_flag = 1'b0;
    else
      nxt_flag = flag_ff;
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      flag_ff <= 1'b0;
    else
      flag_ff <= nxt_flag;
  end

endmodule : pcs_flag

// >>> design/pcs_cmd_status.sv
`timescale 1ns/1ps
module pcs_cmd_status #(
  parameter bit HAS_INITIATOR = 1'b1,
  parameter bit HOT_SWAP_OPT = 1'b0,
  parameter bit FAST_BUS_OPTION = 1'b0
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Configuration access from the target engine
  input wire logic cfg_sel,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  output logic cfg_ack,
  // Decode requests from the target engine
  input wire logic io_hit_raw,
  input wire logic mem_hit_raw,
  output logic io_hit,
  output logic mem_hit,
  // Initiator request
  input wire logic init_req_raw,
  output logic init_req,
  // Parity and system error
  input wire logic par_err_raw,
  output logic par_err_report,
  input wire logic serr_req,
  output logic serr_out,
  output logic serr_oe,
  // Status events from the engines
  input wire logic ev_perr_seen,
  input wire logic ev_sig_tabt,
  input wire logic ev_rcv_tabt,
  input wire logic ev_rcv_mabt,
  input wire logic ev_addr_perr,
  input wire logic ev_data_perr,
  // Command and status views for the engines
  output logic [15:0] cmd_out,
  output logic [15:0] status_out
);

  logic [15:0] cmd_ff; // Command register storage
  logic [15:0] nxt_cmd;
  logic [15:0] status_rd; // Assembled status view
  logic pin_perr_s; // Synchronised parity-error pin level
  logic pin_perr_d_ff; // Delayed copy for edge detect
  logic perr_evt; // Rising edge of the parity-error pin
  logic acc_hit; // Access targets the command/status dword
  logic wr_lo; // Byte write to command low
  logic wr_hi; // Byte write to command high
  logic wr_sts; // Byte write to the status high byte, where the flags live
  logic [4:0] flag_set; // Event strobes per writable flag
  logic [4:0] flag_clr; // Write-one clear strobes
  logic [4:0] flag_q; // Flag values
  logic serr_on_ff; // Registered system-error drive
  pcs_pkg::pcs_cfg_state_type state_ff;
  pcs_pkg::pcs_cfg_state_type nxt_state;
  logic [31:0] rdata_ff;

  // Writable command mask depends on the initiator build
  function automatic logic [15:0] cmd_mask(input bit has_init);
    cmd_mask = pcs_pkg::CMD_RW_TARGET_MASK;
    if (has_init)
      cmd_mask = cmd_mask | pcs_pkg::CMD_RW_INIT_MASK;
  endfunction : cmd_mask

  // Parity-error pin comes from the bus, so it is synchronised first
  pcs_sync #(
    .WIDTH(1)
  ) u_perr_sync (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .din(ev_perr_seen),
    .dout(pin_perr_s)
  );

  // Edge detect on the synchronised level
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      pin_perr_d_ff <= 1'b0;
    else
      pin_perr_d_ff <= pin_perr_s;
  end

  assign perr_evt = pin_perr_s & ~pin_perr_d_ff;

  // Host reaches this dword through a selected configuration cycle
  assign acc_hit = cfg_sel && (cfg_addr[1:0] == 2'h0) &&
                   (cfg_addr[7:2] == pcs_pkg::CFG_CMD_STAT_IDX);
  assign wr_lo = acc_hit && cfg_wr && (state_ff == pcs_pkg::CFG_IDLE) && cfg_be[0];
  assign wr_hi = acc_hit && cfg_wr && (state_ff == pcs_pkg::CFG_IDLE) && cfg_be[1];
  assign wr_sts = acc_hit && cfg_wr && (state_ff == pcs_pkg::CFG_IDLE) && cfg_be[3];

  // Access sequencer: one ack cycle per access, then wait for release
  always_comb
  begin
    case (state_ff)
      pcs_pkg::CFG_IDLE:
      begin
        if (cfg_sel && (cfg_wr || cfg_rd))
          nxt_state = pcs_pkg::CFG_DATA;
        else
          nxt_state = pcs_pkg::CFG_IDLE;
      end
      pcs_pkg::CFG_DATA:
        nxt_state = pcs_pkg::CFG_DONE;
      pcs_pkg::CFG_DONE:
      begin
        // Hold until the select drops so one access is not taken twice
        if (cfg_sel)
          nxt_state = pcs_pkg::CFG_DONE;
        else
          nxt_state = pcs_pkg::CFG_IDLE;
      end
      default:
        nxt_state = pcs_pkg::CFG_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      state_ff <= pcs_pkg::CFG_IDLE;
    else
      state_ff <= nxt_state;
  end

  assign cfg_ack = (state_ff == pcs_pkg::CFG_DATA);

  // Command next value; read-only bits stay zero through the mask
  always_comb
  begin
    nxt_cmd = cmd_ff;
    if (wr_lo)
      nxt_cmd[7:0] = cfg_wdata[7:0];
    if (wr_hi)
      nxt_cmd[15:8] = cfg_wdata[15:8];
    nxt_cmd = nxt_cmd & cmd_mask(HAS_INITIATOR);
  end

  // Command register, cleared on reset
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      cmd_ff <= pcs_pkg::CMD_RESET_VAL;
    else
      cmd_ff <= nxt_cmd;
  end

  // Decode gating
  assign io_hit = io_hit_raw & cmd_ff[pcs_pkg::CMD_IO_EN_BIT];
  assign mem_hit = mem_hit_raw & cmd_ff[pcs_pkg::CMD_MEM_EN_BIT];
  assign init_req = init_req_raw & cmd_ff[pcs_pkg::CMD_INIT_EN_BIT];
  // Parity response only when enabled
  assign par_err_report = par_err_raw & cmd_ff[pcs_pkg::CMD_PAR_RESP_BIT];

  // System-error driver, registered; enable goes off one cycle after command bit 8 is zero
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      serr_on_ff <= 1'b0;
    else
      serr_on_ff <= serr_req & cmd_ff[pcs_pkg::CMD_SERR_EN_BIT];
  end

  // Open-drain: low while driven, high when released like the pull-up
  assign serr_out = ~serr_on_ff;
  assign serr_oe = serr_on_ff;

  // Event set strobes; slot order is status bits 11, 12, 13, 14, 15
  assign flag_set[0] = ev_sig_tabt;
  assign flag_set[1] = ev_rcv_tabt;
  assign flag_set[2] = ev_rcv_mabt;
  // Follows the pin driver itself, so a masked request never sets the flag
  assign flag_set[3] = serr_on_ff;
  // Parity errors are recorded even with the response bit off
  assign flag_set[4] = ev_addr_perr | ev_data_perr;

  // Write-one clears; every flag sits in the top byte lane of the dword
  always_comb
  begin
    flag_clr = '0;
    if (wr_sts)
    begin
      flag_clr[0] = cfg_wdata[16 + pcs_pkg::STS_SIG_TABT_BIT];
      flag_clr[1] = cfg_wdata[16 + pcs_pkg::STS_RCV_TABT_BIT];
      flag_clr[2] = cfg_wdata[16 + pcs_pkg::STS_RCV_MABT_BIT];
      flag_clr[3] = cfg_wdata[16 + pcs_pkg::STS_SIG_SERR_BIT];
      flag_clr[4] = cfg_wdata[16 + pcs_pkg::STS_DET_PERR_BIT];
    end
  end

  logic dpar_q; // Data parity flag of the initiator
  logic dpar_clr; // Write-one clear of that flag
  assign dpar_clr = wr_sts & cfg_wdata[16 + pcs_pkg::STS_DPAR_BIT];

  // Data parity seen by the initiator; absent in target-only builds
  pcs_flag #(
    .PRESENT(HAS_INITIATOR)
  ) u_dpar (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .set_evt(perr_evt),
    .clr_evt(dpar_clr),
    .flag_ff(dpar_q)
  );

  // Signalled target abort is kept in every build
  pcs_flag #(
    .PRESENT(1'b1)
  ) u_sig_tabt (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .set_evt(flag_set[0]),
    .clr_evt(flag_clr[0]),
    .flag_ff(flag_q[0])
  );

  // Received target abort only exists with an initiator
  pcs_flag #(
    .PRESENT(HAS_INITIATOR)
  ) u_rcv_tabt (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .set_evt(flag_set[1]),
    .clr_evt(flag_clr[1]),
    .flag_ff(flag_q[1])
  );

  // Master abort only exists with an initiator
  pcs_flag #(
    .PRESENT(HAS_INITIATOR)
  ) u_rcv_mabt (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .set_evt(flag_set[2]),
    .clr_evt(flag_clr[2]),
    .flag_ff(flag_q[2])
  );

  // Signalled system error is kept in every build
  pcs_flag #(
    .PRESENT(1'b1)
  ) u_sig_serr (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .set_evt(flag_set[3]),
    .clr_evt(flag_clr[3]),
    .flag_ff(flag_q[3])
  );

  // Detected parity error is kept in every build
  pcs_flag #(
    .PRESENT(1'b1)
  ) u_det_perr (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .set_evt(flag_set[4]),
    .clr_evt(flag_clr[4]),
    .flag_ff(flag_q[4])
  );

  // Status view: fixed zeros, the slow DEVSEL field, build options and the sticky flags
  always_comb
  begin
    status_rd = 16'h0000;
    status_rd[pcs_pkg::STS_CAP_LIST_BIT] = HOT_SWAP_OPT;
    status_rd[pcs_pkg::STS_FAST_BUS_BIT] = FAST_BUS_OPTION;
    status_rd[pcs_pkg::STS_DEVSEL_LO_BIT +: 2] = pcs_pkg::STS_DEVSEL_SLOW;
    status_rd[pcs_pkg::STS_DPAR_BIT] = dpar_q;
    status_rd[pcs_pkg::STS_SIG_TABT_BIT] = flag_q[0];
    status_rd[pcs_pkg::STS_RCV_TABT_BIT] = flag_q[1];
    status_rd[pcs_pkg::STS_RCV_MABT_BIT] = flag_q[2];
    status_rd[pcs_pkg::STS_SIG_SERR_BIT] = flag_q[3];
    status_rd[pcs_pkg::STS_DET_PERR_BIT] = flag_q[4];
  end

  // Read data is captured as the access is taken and held through the ack cycle
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      rdata_ff <= 32'h0000_0000;
    else if ((state_ff == pcs_pkg::CFG_IDLE) && cfg_sel && cfg_rd)
    begin
      // Unimplemented dwords read back as zero
      if (acc_hit)
        rdata_ff <= {status_rd, cmd_ff};
      else
        rdata_ff <= 32'h0000_0000;
    end
  end

  assign cfg_rdata = rdata_ff;

  // Register views for the engines
  assign cmd_out = cmd_ff;
  assign status_out = status_rd;

endmodule : pcs_cmd_status

// >>> test/pcs_monitor.sv
`timescale 1ns/1ps
// Port-side checker for the command/status pair
module pcs_monitor #(
  parameter bit HOT_SWAP_OPT = 1'b0,
  parameter bit FAST_BUS_OPTION = 1'b0
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Raw status events
  input wire logic ev_sig_tabt,
  input wire logic ev_addr_perr,
  input wire logic ev_data_perr,
  // Register views and gated outputs
  input wire logic [15:0] cmd_out,
  input wire logic [15:0] status_out,
  input wire logic io_hit,
  input wire logic mem_hit,
  input wire logic init_req,
  input wire logic par_err_report,
  input wire logic serr_oe
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // Two cycles of command history; a gate may lag its enable by a register stage
  logic [15:0] cmd_d1_ff;
  logic [15:0] cmd_d2_ff;
  wire logic [15:0] off = ~(cmd_out | cmd_d1_ff | cmd_d2_ff);
  // History register
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cmd_d1_ff <= 16'h0000;
      cmd_d2_ff <= 16'h0000;
    end
    else
    begin
      cmd_d1_ff <= cmd_out;
      cmd_d2_ff <= cmd_d1_ff;
    end
  end
  // Either parity event kind
  sequence perr_evt;
    ev_addr_perr || ev_data_perr;
  endsequence
  cmd_rsv_a: assert property ((cmd_out & 16'hFEB8) == 16'h0000)
    else $error("reserved command bit set");
  sts_rsv_a: assert property ((status_out & 16'h00CF) == 16'h0000)
    else $error("reserved status bit set");
  devsel_fix_a: assert property (status_out[10:9] == pcs_pkg::STS_DEVSEL_SLOW)
    else $error("devsel timing field wrong");
  build_opt_a: assert property (status_out[5:4] == {FAST_BUS_OPTION, HOT_SWAP_OPT})
    else $error("build option bits wrong");
  io_gate_a: assert property (off[0] |-> !io_hit)
    else $error("io hit while disabled");
  mem_gate_a: assert property (off[1] |-> !mem_hit)
    else $error("memory hit while disabled");
  init_gate_a: assert property (off[2] |-> !init_req)
    else $error("initiator request while disabled");
  par_gate_a: assert property (off[6] |-> !par_err_report)
    else $error("parity report while disabled");
  serr_gate_a: assert property (off[8] |-> !serr_oe)
    else $error("system error driver on while disabled");
  tabt_set_a: assert property (ev_sig_tabt |-> ##[1:4] status_out[11])
    else $error("target abort flag not set");
  perr_set_a: assert property (perr_evt |-> ##[1:4] status_out[15])
    else $error("parity flag not set");
  serr_flag_a: assert property (serr_oe |-> ##1 status_out[14])
    else $error("system error flag not set");
endmodule : pcs_monitor

bind pcs_cmd_status pcs_monitor #(.HOT_SWAP_OPT(HOT_SWAP_OPT), .FAST_BUS_OPTION(FAST_BUS_OPTION))
  u_mon (.ref_clk(ref_clk), .rstn(rstn), .ev_sig_tabt(ev_sig_tabt), .ev_addr_perr(ev_addr_perr),
  .ev_data_perr(ev_data_perr), .cmd_out(cmd_out), .status_out(status_out), .io_hit(io_hit),
  .mem_hit(mem_hit), .init_req(init_req), .par_err_report(par_err_report), .serr_oe(serr_oe));

// >>> test/pcs_host.sv
`timescale 1ns/1ps
// Host model issuing configuration dword cycles
module pcs_host (
  // Clock
  input wire logic ref_clk,
  // Request
  output logic cfg_sel = 1'b0,
  output logic cfg_wr = 1'b0,
  output logic cfg_rd = 1'b0,
  output logic [7:0] cfg_addr = 8'h00,
  output logic [3:0] cfg_be = 4'h0,
  output logic [31:0] cfg_wdata = 32'h0000_0000,
  // Answer
  input wire logic [31:0] cfg_rdata,
  input wire logic cfg_ack
);
  // Hold the whole request until ack is sampled; on release the address and write data are inverted
  task automatic xfer(input logic wr, input logic [3:0] be, input logic [31:0] d,
    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge ref_clk);
    cfg_sel <= 1'b1;
    cfg_wr <= wr;
    cfg_rd <= ~wr;
    cfg_addr <= {pcs_pkg::CFG_CMD_STAT_IDX, 2'h0};
    cfg_be <= be;
    cfg_wdata <= d;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (cfg_ack !== 1'b1 && n < 64);
    q = cfg_rdata;
    cfg_sel <= 1'b0;
    cfg_wr <= 1'b0;
    cfg_rd <= 1'b0;
    cfg_addr <= ~cfg_addr;
    cfg_wdata <= ~d;
  endtask : xfer
endmodule : pcs_host

// >>> test/testbench.sv
`timescale 1ns/1ps
// Register-level bench for the command/status pair
module testbench;
  logic ref_clk;
  logic rstn = 1'b0;
  logic [4:0] raw = 5'h00;
  logic [5:0] ev = 6'h00;
  logic cfg_sel, cfg_wr, cfg_rd, cfg_ack;
  logic [7:0] cfg_addr;
  logic [3:0] cfg_be;
  logic [31:0] cfg_wdata, cfg_rdata;
  logic io_hit, mem_hit, init_req, par_err_report, serr_oe, serr_out;
  int num_errors = 0;
  int checks_done = 0;
  // Status flag position raised by each event line
  int pos[6] = '{8, 11, 12, 13, 15, 15};
  pcs_host host (.ref_clk(ref_clk), .cfg_sel(cfg_sel), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .cfg_ack(cfg_ack));
  pcs_cmd_status #(.HAS_INITIATOR(1'b1), .HOT_SWAP_OPT(1'b1), .FAST_BUS_OPTION(1'b1)) dut (
    .ref_clk(ref_clk), .rstn(rstn), .cfg_sel(cfg_sel), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .cfg_ack(cfg_ack), .io_hit_raw(raw[0]), .mem_hit_raw(raw[1]), .io_hit(io_hit),
    .mem_hit(mem_hit), .init_req_raw(raw[2]), .init_req(init_req), .par_err_raw(raw[3]),
    .par_err_report(par_err_report), .serr_req(raw[4]), .serr_out(serr_out), .serr_oe(serr_oe),
    .ev_perr_seen(ev[0]), .ev_sig_tabt(ev[1]), .ev_rcv_tabt(ev[2]), .ev_rcv_mabt(ev[3]),
    .ev_addr_perr(ev[4]), .ev_data_perr(ev[5]), .cmd_out(), .status_out());
  // Clock
  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic rd(input string nm, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    host.xfer(1'b0, 4'hF, 32'h0000_0000, q);
    chk(nm, e & m, q & m);
  endtask : rd
  task automatic wr(input logic [3:0] be, input logic [31:0] d);
    logic [31:0] q;
    host.xfer(1'b1, be, d, q);
  endtask : wr
  function automatic logic [31:0] gates();
    return {26'h0, serr_out, serr_oe, par_err_report, init_req, mem_hit, io_hit};
  endfunction : gates
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : stop_test
  // Watchdog: the sequence needs a couple of hundred cycles at most
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    num_errors++;
    stop_test();
  end
  // Main sequence
  initial
  begin
    repeat (8) @(posedge ref_clk);
    rstn <= 1'b1;
    rd("after reset", 32'hFFFF_FFFF, 32'h0430_0000);
    $display("test reset done");
    wr(4'h3, 32'hFFFF_FFFF);
    rd("command", 32'h0000_FFFF, 32'h0000_0147);
    raw <= 5'h1F;
    repeat (4) @(posedge ref_clk);
    chk("gates on", 32'h0000_001F, gates());
    rd("system error flag", 32'h4000_0000, 32'h4000_0000);
    wr(4'h3, 32'h0000_0000);
    repeat (4) @(posedge ref_clk);
    chk("gates off", 32'h0000_0020, gates());
    raw <= 5'h00;
    $display("test gates done");
    wr(4'hC, 32'hFFFF_0000);
    rd("flags cleared", 32'hF900_0000, 32'h0000_0000);
    // Each event with command bit 6 off; a zero write must keep the flag
    for (int i = 0; i < 6; i++)
    begin
      ev[i] <= 1'b1;
      @(posedge ref_clk);
      ev[i] <= 1'b0;
      repeat (4) @(posedge ref_clk);
      wr(4'hC, 32'h0000_0000);
      rd("flag set", 32'h1 << (16 + pos[i]), 32'h1 << (16 + pos[i]));
      wr(4'hC, 32'h1 << (16 + pos[i]));
      rd("flag cleared", 32'hF900_0000, 32'h0000_0000);
    end
    $display("test flags done");
    stop_test();
  end
endmodule : testbench
